/* File: hdl/tpm_engine.sv */
// Table pointer move engine: remove-from-bottom and store-to-table.
// Assumes one request per scan, word memory with one-cycle reads.
`include "tpm_consts.svh"
module tpm_engine
	import tpm_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic exec,
	input wire tpm_op_t op,
	input wire logic [`TPM_LEN_W-1:0] table_len,
	input wire tpm_addr_t table_base,
	input wire tpm_addr_t operand_addr,
	input wire logic scan_end,
	input wire logic other_flag_op,
	input wire tpm_word_t mem_rdata,
	output logic mem_rd,
	output logic mem_wr,
	output tpm_addr_t mem_addr,
	output tpm_word_t mem_wdata,
	output logic busy,
	output logic done,
	output logic moved,
	output logic table_limit_flag
);
	tpm_state_t state_reg;
	tpm_op_t op_reg;
	logic [`TPM_LEN_W-1:0] len_reg;
	tpm_addr_t base_reg;
	tpm_addr_t opnd_reg;
	tpm_word_t ptr_reg;
	tpm_word_t data_reg;
	tpm_word_t ptr_new;
	tpm_addr_t entry_addr;
	logic move_ok;
	logic limit;
	logic rd_req;
	logic wr_req;
	tpm_addr_t req_addr;
	tpm_word_t req_data;

	tpm_ptr_calc u_calc (
		.op(op_reg),
		.ptr(ptr_reg),
		.len(len_reg),
		.base(base_reg),
		.ptr_new(ptr_new),
		.entry_addr(entry_addr),
		.move_ok(move_ok),
		.limit(limit)
	);

	// Sequence of one move
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= TPM_IDLE;
		end else begin
			unique case (state_reg)
				TPM_IDLE: begin
					if (exec) begin
						state_reg <= TPM_RD_PTR;
					end
				end
				TPM_RD_PTR: state_reg <= TPM_WAIT_PTR;
				TPM_WAIT_PTR: state_reg <= TPM_RD_DATA;
				TPM_RD_DATA: begin
					if (!move_ok) begin
						state_reg <= TPM_DONE;
					end else begin
						state_reg <= TPM_WAIT_DATA;
					end
				end
				TPM_WAIT_DATA: state_reg <= TPM_WR_DATA;
				TPM_WR_DATA: state_reg <= TPM_WR_PTR;
				TPM_WR_PTR: state_reg <= TPM_DONE;
				TPM_DONE: state_reg <= TPM_IDLE;
			endcase
		end
	end

	// Operands latched at request
	always_ff @(posedge clk) begin
		if (srst) begin
			op_reg <= TPM_OP_REMOVE;
			len_reg <= '0;
			base_reg <= '0;
			opnd_reg <= '0;
		end else if (state_reg == TPM_IDLE && exec) begin
			op_reg <= op;
			len_reg <= table_len;
			base_reg <= table_base;
			opnd_reg <= operand_addr;
		end
	end

	// Pointer and data captured from memory
	always_ff @(posedge clk) begin
		if (srst) begin
			ptr_reg <= '0;
			data_reg <= '0;
		end else begin
			if (state_reg == TPM_WAIT_PTR) begin
				ptr_reg <= mem_rdata;
			end
			if (state_reg == TPM_WAIT_DATA) begin
				data_reg <= mem_rdata;
			end
		end
	end

	// Memory requests per state
	always_comb begin
		rd_req = 1'b0;
		wr_req = 1'b0;
		req_addr = base_reg;
		req_data = '0;
		unique case (state_reg)
			TPM_RD_PTR: rd_req = 1'b1;
			TPM_RD_DATA: begin
				if (move_ok) begin
					rd_req = 1'b1;
					if (op_reg == TPM_OP_REMOVE) begin
						req_addr = entry_addr;
					end else begin
						req_addr = opnd_reg;
					end
				end
			end
			TPM_WR_DATA: begin
				wr_req = 1'b1;
				req_data = data_reg;
				if (op_reg == TPM_OP_REMOVE) begin
					req_addr = opnd_reg;
				end else begin
					req_addr = entry_addr;
				end
			end
			TPM_WR_PTR: begin
				wr_req = 1'b1;
				req_data = ptr_new;
			end
			default: begin
			end
		endcase
	end

	tpm_mem_port u_port (
		.clk(clk),
		.srst(srst),
		.rd_req(rd_req),
		.wr_req(wr_req),
		.addr_in(req_addr),
		.data_in(req_data),
		.mem_rd(mem_rd),
		.mem_wr(mem_wr),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata)
	);

	// Status outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			busy <= 1'b0;
			done <= 1'b0;
			moved <= 1'b0;
		end else begin
			busy <= (state_reg == TPM_IDLE && exec) ||
				(state_reg != TPM_IDLE && state_reg != TPM_DONE);
			done <= (state_reg == TPM_WR_PTR) ||
				(state_reg == TPM_RD_DATA && !move_ok);
			moved <= (state_reg == TPM_WR_PTR);
		end
	end

	// Limit flag: loaded by a move or a refused move, cleared by scan end or other user
	always_ff @(posedge clk) begin
		if (srst) begin
			table_limit_flag <= 1'b0;
		end else if (state_reg == TPM_WR_PTR) begin
			table_limit_flag <= limit;
		end else if (state_reg == TPM_RD_DATA && !move_ok) begin
			table_limit_flag <= (op_reg == TPM_OP_REMOVE);
		end else if (scan_end || other_flag_op) begin
			table_limit_flag <= 1'b0;
		end
	end
endmodule

/* File: hdl/tpm_consts.svh */
// Constants of the table pointer move engine: widths, pointer values, limits.
// Assumes a word memory with one-cycle read latency.
// Function
// - Remove copies entry, then pointer minus one
// - Remove reads pointer from table first word
// - One remove move per scan while enabled
// - No remove moves once pointer is zero
// - Remove pointer one selects first data word
// - Remove sets limit flag at pointer zero
// - Flag holds until next flag user or scan end
// - Data entries start after pointer word
// - Remove destination is operand address
// - Store copies source, pointer plus one
// - Store reads pointer from table first word
// - Store pointer at length wraps to one
// - Store pointer zero or length hits entry one
// - Store increments pointer before selecting entry
// - Store sets limit flag at pointer equals length
// - Store moves nothing when pointer out of range
// - Store source is operand address
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH
`define TPM_ADDR_W 16
`define TPM_DATA_W 16
`define TPM_LEN_W 8
`define TPM_PTR_ZERO 16'h0000
`define TPM_PTR_ONE 16'h0001
`define TPM_LEN_MAX 8'hFF
`endif

/* File: hdl/tpm_pkg.sv */
// Types of the table pointer move engine.
// Assumes tpm_consts.svh is on the include path.
`include "tpm_consts.svh"
package tpm_pkg;
	typedef logic [`TPM_ADDR_W-1:0] tpm_addr_t;
	typedef logic [`TPM_DATA_W-1:0] tpm_word_t;
	typedef enum logic {TPM_OP_REMOVE, TPM_OP_STORE} tpm_op_t;
	typedef enum {TPM_IDLE, TPM_RD_PTR, TPM_WAIT_PTR, TPM_RD_DATA,
		TPM_WAIT_DATA, TPM_WR_DATA, TPM_WR_PTR, TPM_DONE} tpm_state_t;
endpackage

/* File: hdl/tpm_ptr_calc.sv */
// Next pointer, entry address and limit flag for both operations.
// Purely combinational; fed by registered operands.
`include "tpm_consts.svh"
module tpm_ptr_calc
	import tpm_pkg::*;
(
	input wire tpm_op_t op,
	input wire tpm_word_t ptr,
	input wire logic [`TPM_LEN_W-1:0] len,
	input wire tpm_addr_t base,
	output tpm_word_t ptr_new,
	output tpm_addr_t entry_addr,
	output logic move_ok,
	output logic limit
);
	tpm_word_t len_w;
	tpm_word_t sel;
	assign len_w = {{(`TPM_DATA_W-`TPM_LEN_W){1'b0}}, len};
	always_comb begin
		if (op == TPM_OP_REMOVE) begin
			move_ok = (ptr != `TPM_PTR_ZERO);
			ptr_new = ptr - `TPM_PTR_ONE;
			sel = ptr;
			limit = (ptr_new == `TPM_PTR_ZERO);
		end else begin
			move_ok = (ptr <= len_w);
			if (ptr == len_w || ptr == `TPM_PTR_ZERO) begin
				ptr_new = `TPM_PTR_ONE;
			end else begin
				ptr_new = ptr + `TPM_PTR_ONE;
			end
			sel = ptr_new;
			limit = (ptr_new == len_w);
		end
	end
	assign entry_addr = base + sel;
endmodule

/* File: hdl/tpm_mem_port.sv */
// Registered word memory request port.
// Assumes read data returns one cycle after a read request.
`include "tpm_consts.svh"
module tpm_mem_port
	import tpm_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire tpm_addr_t addr_in,
	input wire tpm_word_t data_in,
	output logic mem_rd,
	output logic mem_wr,
	output tpm_addr_t mem_addr,
	output tpm_word_t mem_wdata
);
	always_ff @(posedge clk) begin
		if (srst) begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
		end else begin
			mem_rd <= rd_req;
			mem_wr <= wr_req;
			if (rd_req || wr_req) begin
				mem_addr <= addr_in;
				mem_wdata <= data_in;
			end
		end
	end
endmodule

/* File: sim/tpm_mem_model.sv */
// Word memory partner; answers a read in the strobe cycle.
// Assumes the bench preloads mem; low address byte only.
module tpm_mem_model
	import tpm_pkg::*;
(
	input wire logic clk,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire tpm_addr_t mem_addr,
	input wire tpm_word_t mem_wdata,
	output tpm_word_t mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	tpm_word_t mem [256];
	tpm_word_t junk_reg = 16'h5A3C;
	always @(posedge clk) begin
		junk_reg <= ~junk_reg;
		if (mem_wr)
			mem[mem_addr[7:0]] <= mem_wdata;
	end
	assign mem_rdata = mem_rd ? mem[mem_addr[7:0]] : junk_reg;
endmodule

/* File: sim/tpm_engine_props.sv */
// Port checker for the engine.
// Assumes a bind to tpm_engine.
module tpm_engine_props
	import tpm_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic scan_end,
	input wire logic other_flag_op,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire tpm_word_t mem_wdata,
	input wire logic busy,
	input wire logic done,
	input wire logic moved,
	input wire logic table_limit_flag
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence clr_s;
		(scan_end || other_flag_op) ##1 !done;
	endsequence
	sequence wr2_s;
		mem_wr ##1 mem_wr;
	endsequence
	ptr_read_a: assert property ($rose(busy) |=> mem_rd)
		else $error("no pointer read");
	two_writes_a: assert property (wr2_s |-> moved && done)
		else $error("writes without move");
	move_writes_a: assert property (moved |-> mem_wr && $past(mem_wr))
		else $error("move without writes");
	refuse_quiet_a: assert property (done && !moved |-> !mem_wr)
		else $error("refused move wrote");
	done_idle_a: assert property (done |=> !busy && !done)
		else $error("busy after done");
	flag_clear_a: assert property (clr_s |-> !table_limit_flag)
		else $error("flag not cleared");
	flag_hold_a: assert property (busy && !scan_end && !other_flag_op
		##1 !done |-> $stable(table_limit_flag))
		else $error("flag changed");
	zero_flag_a: assert property (moved && mem_wdata == 16'h0000
		|-> table_limit_flag)
		else $error("no flag at zero");
endmodule

/* File: sim/tpm_engine_tb.sv */
// Bench: driver notes results, monitor checks them at done.
// Assumes partner model and checker compiled first.
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin \
	bad_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tpm_engine_tb
	import tpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic mv, fl; tpm_word_t p, a, d;} tpm_note_t;
	logic clk = 0, srst = 1, exec = 0, scan_end = 0, other_flag_op = 0;
	logic mem_rd, mem_wr, busy, done, moved, table_limit_flag;
	logic [7:0] table_len = 8'h00;
	tpm_op_t op = TPM_OP_REMOVE;
	tpm_addr_t table_base = 16'h0000, operand_addr = 16'h0000, mem_addr;
	tpm_word_t mem_rdata, mem_wdata, ep, sh [256];
	logic [31:0] rnd = 32'hA1444F27;
	tpm_note_t q [$], got;
	int bad_count = 0, num_checks = 0, cyc = 0;
	always #2.5 clk = ~clk;
	tpm_engine dut_u (.*);
	tpm_mem_model mem_u (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic put(input tpm_addr_t b, input tpm_word_t v);
		@(negedge clk);
		mem_u.mem[b[7:0]] = v;
		sh[b[7:0]] = v;
		ep = v;
	endtask
	task automatic mv(input tpm_op_t o, input logic [7:0] l,
		input tpm_addr_t b, input tpm_addr_t a);
		tpm_note_t n;
		int k = 0;
		if (o == TPM_OP_REMOVE)
			n = '{ep != 0, ep <= 1, ep - 1, a, sh[8'(b + ep)]};
		else begin
			rnd = lfsr(rnd);
			mem_u.mem[a[7:0]] = rnd[15:0];
			sh[a[7:0]] = rnd[15:0];
			n.p = (ep == 0 || ep == l) ? 16'h0001 : ep + 1;
			n = '{ep <= l, n.p == l, n.p, b + n.p, sh[a[7:0]]};
		end
		if (n.mv) begin
			sh[n.a[7:0]] = n.d;
			ep = n.p;
		end
		q.push_back(n);
		@(posedge clk);
		exec <= 1'b1;
		op <= o;
		table_len <= l;
		table_base <= b;
		operand_addr <= a;
		do @(negedge clk); while (done !== 1'b1 && ++k < 20);
		@(posedge clk);
		exec <= 1'b0;
	endtask
	task automatic clr(input logic w);
		@(posedge clk);
		scan_end <= !w;
		other_flag_op <= w;
		@(posedge clk);
		scan_end <= 1'b0;
		other_flag_op <= 1'b0;
		@(negedge clk);
		`CHK("flag clear", 1'b0, table_limit_flag)
	endtask
	always @(negedge clk)
		if (done === 1'b1 && q.size() > 0) begin
			got = q.pop_front();
			`CHK("moved", got.mv, moved)
			`CHK("flag", got.fl, table_limit_flag)
			if (got.mv)
				`CHK("pointer", got.p, mem_wdata)
			if (got.mv)
				`CHK("data", got.d, mem_u.mem[got.a[7:0]])
		end
	always @(posedge clk)
		if (++cyc > 1000) begin
			bad_count++;
			stop_test();
		end
	initial begin
		for (int i = 0; i < 256; i++) begin
			rnd = lfsr(rnd);
			mem_u.mem[i] = rnd[15:0];
			sh[i] = rnd[15:0];
		end
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		put(16'h0010, 16'h0003);
		repeat (4) mv(TPM_OP_REMOVE, 8'h06, 16'h0010, 16'h0040);
		clr(1'b0);
		$display("remove test done");
		put(16'h0020, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			mv(TPM_OP_STORE, 8'h03, 16'h0020, 16'h0041);
			if (i == 2)
				clr(1'b1);
		end
		$display("store test done");
		put(16'h0020, 16'h0005);
		mv(TPM_OP_STORE, 8'h03, 16'h0020, 16'h0041);
		put(16'h0030, 16'h00FF);
		mv(TPM_OP_STORE, 8'hFF, 16'h0030, 16'h0041);
		$display("limit test done");
		stop_test();
	end
endmodule
bind tpm_engine tpm_engine_props chk_u (.*);
